//--- design/capture_buffer_and_accumulator_b.sv
// Capture buffering, 8-bit and 16-bit pulse accumulators, timer port control
`timescale 1ns/1ps

module capture_buffer_and_accumulator_b
    import capbuf_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_special_mode,
    input wire logic i_fast_flag_clear,
    input wire logic i_main_timer_enable,
    input wire logic i_prescale_tick,
    input wire logic i_accum_a_enable,
    input wire logic i_modcount_zero,
    input wire logic [7:0] i_timer_pin,
    input wire logic [7:0] i_compare_active,
    input wire logic [7:0] i_compare_level,
    output logic [7:0] o_timer_pin_out,
    output logic [7:0] o_timer_pin_oe,
    output logic [7:0] o_capture_event,
    output logic [3:0] o_capture_flag_set,
    output logic o_counter_overflow,
    output logic [15:0] o_free_running_counter,
    output logic o_accum_b_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] input_control_system_ff;
    logic input_control_system_locked_ff;
    logic [7:0] overwrite_guard_ff;
    logic [7:0] accum_enable_ff;
    logic [7:0] timer_test_control_ff;
    logic [7:0] port_latch_ff;
    logic [7:0] timer_port_direction_ff;
    logic [7:0] accum_b_control_ff;
    logic accum_b_overflow_flag_ff;
    logic [7:0] accum_ff [4];
    logic [7:0] accum_hold_ff [4];
    logic [15:0] capture_ff [4];
    logic [15:0] capture_hold_ff [4];
    logic [3:0] capture_full_ff;
    logic [3:0] hold_full_ff;
    logic [7:0] pin_prev_ff;
    logic [15:0] counter_ff;
    logic [7:0] rdata_ff;
    logic [3:0] flag_set_ff;
    logic [7:0] event_ff;
    logic overflow_ff;
    logic [7:0] pin_out_ff;
    logic [7:0] pin_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decoded controls
    logic [3:0] share_channel_pair;
    logic flag_on_latch_mode;
    logic accum_saturate;
    logic hold_buffer_enable;
    logic latch_not_queue;
    logic queue_mode;
    logic latch_mode;
    logic force_latch_wr;
    logic latch_evt;
    logic accum_b_enable;
    logic divider_bypass;
    logic [7:0] pin_edge;
    logic [7:0] chan_evt;
    logic [3:0] no_overwrite;
    logic [3:0] accum_en;
    logic [3:0] cap_rd;
    logic [3:0] hold_rd;
    logic [3:0] hold_load;
    logic [3:0] cap_load;
    logic [7:0] dir_eff;
    logic accum_b_set;
    logic accum_b_clr;
    logic [15:0] accum_b_16bit;
    logic [7:0] rd_mux;

    assign share_channel_pair = input_control_system_ff[SHARE_LSB +: 4];
    assign flag_on_latch_mode = input_control_system_ff[FLAG_ON_LATCH_BIT];
    assign accum_saturate = input_control_system_ff[ACCUM_SATURATE_BIT];
    assign hold_buffer_enable = input_control_system_ff[HOLD_BUFFER_ENABLE_BIT];
    assign latch_not_queue = input_control_system_ff[LATCH_NOT_QUEUE_BIT];
    assign queue_mode = hold_buffer_enable & ~latch_not_queue;
    assign latch_mode = hold_buffer_enable & latch_not_queue;
    assign force_latch_wr = i_wr & (i_addr == OFS_MODCOUNT_CONTROL) & i_wdata[FORCE_LATCH_BIT];
    assign latch_evt = latch_mode & (force_latch_wr | i_modcount_zero);
    assign accum_b_enable = accum_b_control_ff[ACCUM_B_ENABLE_BIT];
    assign divider_bypass = timer_test_control_ff[DIVIDER_BYPASS_BIT];
    assign no_overwrite = overwrite_guard_ff[3:0];
    assign accum_b_16bit = {accum_ff[1], accum_ff[0]};
    assign pin_edge = i_timer_pin & ~pin_prev_ff;

    always_comb begin
        chan_evt[3:0] = pin_edge[3:0];
        for (int i = 0; i < 4; i++) begin
            chan_evt[i + 4] = share_channel_pair[i] ? pin_edge[i] : pin_edge[i + 4];
        end
    end

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            cap_rd[n] = i_rd & (i_addr[7:1] == 7'(({1'b0, OFS_TC0} + 9'(2 * n)) >> 1));
            hold_rd[n] = i_rd & (i_addr[7:1] == 7'(({1'b0, OFS_TC0_HOLDING} + 9'(2 * n)) >> 1));
            cap_load[n] = chan_evt[n] & (~no_overwrite[n] | ~capture_full_ff[n]
                | (queue_mode & ~hold_full_ff[n]));
            hold_load[n] = chan_evt[n] & queue_mode
                & (~no_overwrite[n] | (capture_full_ff[n] & ~hold_full_ff[n]));
        end
    end

    always_comb begin
        accum_en[0] = ~accum_b_enable & accum_enable_ff[0];
        accum_en[1] = ~accum_b_enable & accum_enable_ff[1];
        accum_en[2] = ~i_accum_a_enable & accum_enable_ff[2];
        accum_en[3] = ~i_accum_a_enable & accum_enable_ff[3];
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register writes
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            input_control_system_ff <= RST_BYTE;
            input_control_system_locked_ff <= 1'b0;
        end else if (i_wr && i_addr == OFS_INPUT_CONTROL_SYSTEM) begin
            if (i_special_mode || !input_control_system_locked_ff) begin
                input_control_system_ff <= i_wdata;
            end
            if (!i_special_mode) begin
                input_control_system_locked_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            overwrite_guard_ff <= RST_BYTE;
            accum_enable_ff <= RST_BYTE;
            timer_test_control_ff <= RST_BYTE;
            timer_port_direction_ff <= RST_BYTE;
            accum_b_control_ff <= RST_BYTE;
        end else if (i_wr) begin
            case (i_addr)
                OFS_OVERWRITE_GUARD: overwrite_guard_ff <= {4'h0, i_wdata[3:0]};
                OFS_ACCUM_ENABLE: accum_enable_ff <= {4'h0, i_wdata[3:0]};
                OFS_TIMER_TEST_CONTROL: begin
                    if (i_special_mode) begin
                        timer_test_control_ff <= i_wdata & 8'h02;
                    end
                end
                OFS_TIMER_PORT_DIRECTION: timer_port_direction_ff <= i_wdata;
                OFS_ACCUM_B_CONTROL: accum_b_control_ff <= i_wdata & 8'h42;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer port
    // compare forces output
    assign dir_eff = timer_port_direction_ff | i_compare_active;

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            port_latch_ff <= RST_BYTE;
        end else if (i_wr && i_addr == OFS_TIMER_PORT_VALUE) begin
            port_latch_ff <= i_wdata;
        end
    end

    // Registered pin drive costs one cycle of lag after a write
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pin_out_ff <= RST_BYTE;
            pin_oe_ff <= RST_BYTE;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pin_out_ff[i] <= i_compare_active[i] ? i_compare_level[i] : port_latch_ff[i];
            end
            pin_oe_ff <= dir_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running counter
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            counter_ff <= RST_WORD;
            overflow_ff <= 1'b0;
        end else begin
            overflow_ff <= 1'b0;
            if (i_main_timer_enable) begin
                if (divider_bypass) begin
                    counter_ff[7:0] <= counter_ff[7:0] + 8'h01;
                    counter_ff[15:8] <= counter_ff[15:8] + 8'h01;
                    overflow_ff <= (counter_ff[15:8] == BYTE_ONES);
                end else if (i_prescale_tick) begin
                    counter_ff <= counter_ff + 16'h0001;
                    overflow_ff <= (counter_ff == WORD_ONES);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture channels 0..3
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pin_prev_ff <= RST_BYTE;
            event_ff <= RST_BYTE;
        end else begin
            pin_prev_ff <= i_timer_pin;
            event_ff <= chan_evt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            capture_full_ff <= 4'h0;
            hold_full_ff <= 4'h0;
            flag_set_ff <= 4'h0;
            for (int n = 0; n < 4; n++) begin
                capture_ff[n] <= RST_WORD;
                capture_hold_ff[n] <= RST_WORD;
            end
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (cap_rd[n]) begin
                    capture_full_ff[n] <= 1'b0;
                end
                if (hold_rd[n]) begin
                    hold_full_ff[n] <= 1'b0;
                end
                if (latch_evt && !(no_overwrite[n] && hold_full_ff[n])) begin
                    capture_hold_ff[n] <= capture_ff[n];
                    hold_full_ff[n] <= 1'b1;
                    capture_full_ff[n] <= 1'b0;
                end
                if (hold_load[n]) begin
                    capture_hold_ff[n] <= capture_ff[n];
                    hold_full_ff[n] <= 1'b1;
                end
                if (cap_load[n]) begin
                    capture_ff[n] <= counter_ff;
                    capture_full_ff[n] <= 1'b1;
                end
                flag_set_ff[n] <= (flag_on_latch_mode && queue_mode) ? hold_load[n]
                    : chan_evt[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse accumulators
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            for (int n = 0; n < 4; n++) begin
                accum_ff[n] <= RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (i_wr && i_addr == 8'(OFS_ACCUM0_COUNT - 8'(n))) begin
                    accum_ff[n] <= i_wdata;
                end else if (latch_evt && !(n < 2 && accum_b_enable)) begin
                    accum_ff[n] <= RST_BYTE;
                end else if (n < 2 && accum_b_enable) begin
                    if (chan_evt[0] && (n == 0 || accum_ff[0] == BYTE_ONES)) begin
                        accum_ff[n] <= accum_ff[n] + 8'h01;
                    end
                end else if (accum_en[n] && chan_evt[n]) begin
                    if (!(accum_saturate && accum_ff[n] == BYTE_ONES)) begin
                        accum_ff[n] <= accum_ff[n] + 8'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            for (int n = 0; n < 4; n++) begin
                accum_hold_ff[n] <= RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (i_wr && i_addr == 8'(OFS_ACCUM0_HOLDING - 8'(n))) begin
                    accum_hold_ff[n] <= i_wdata;
                end else if (latch_evt && accum_en[n]) begin
                    accum_hold_ff[n] <= accum_ff[n];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator B overflow
    // overflow sources
    assign accum_b_set = accum_b_enable
        ? (chan_evt[0] && accum_b_16bit == WORD_ONES)
        : (accum_en[1] && chan_evt[1] && !accum_saturate && accum_ff[1] == BYTE_ONES);
    // clear by write or fast access
    assign accum_b_clr = (i_wr && i_addr == OFS_ACCUM_B_FLAGS && i_wdata[ACCUM_B_OVERFLOW_BIT])
        || (i_fast_flag_clear && (i_wr || i_rd)
            && (i_addr == OFS_ACCUM1_COUNT || i_addr == OFS_ACCUM0_COUNT));

    // Set beats a clear in the same cycle so no rollover is missed
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            accum_b_overflow_flag_ff <= 1'b0;
        end else begin
            accum_b_overflow_flag_ff <= accum_b_set
                | (accum_b_overflow_flag_ff & ~accum_b_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        rd_mux = RST_BYTE;
        case (i_addr)
            OFS_ACCUM3_COUNT: rd_mux = accum_ff[3];
            OFS_ACCUM2_COUNT: rd_mux = accum_ff[2];
            OFS_ACCUM1_COUNT: rd_mux = accum_ff[1];
            OFS_ACCUM0_COUNT: rd_mux = accum_ff[0];
            OFS_ACCUM_ENABLE: rd_mux = accum_enable_ff;
            OFS_OVERWRITE_GUARD: rd_mux = overwrite_guard_ff;
            OFS_INPUT_CONTROL_SYSTEM: rd_mux = input_control_system_ff;
            OFS_TIMER_TEST_CONTROL: rd_mux = timer_test_control_ff;
            OFS_TIMER_PORT_VALUE: rd_mux = (dir_eff & port_latch_ff) | (~dir_eff & i_timer_pin);
            OFS_TIMER_PORT_DIRECTION: rd_mux = timer_port_direction_ff;
            OFS_ACCUM_B_CONTROL: rd_mux = accum_b_control_ff;
            OFS_ACCUM_B_FLAGS: rd_mux = {6'h00, accum_b_overflow_flag_ff, 1'b0};
            OFS_ACCUM3_HOLDING: rd_mux = accum_hold_ff[3];
            OFS_ACCUM2_HOLDING: rd_mux = accum_hold_ff[2];
            OFS_ACCUM1_HOLDING: rd_mux = accum_hold_ff[1];
            OFS_ACCUM0_HOLDING: rd_mux = accum_hold_ff[0];
            default: begin
                for (int n = 0; n < 4; n++) begin
                    if (cap_rd[n]) begin
                        rd_mux = i_addr[0] ? capture_ff[n][7:0] : capture_ff[n][15:8];
                    end
                    if (hold_rd[n]) begin
                        rd_mux = i_addr[0] ? capture_hold_ff[n][7:0]
                            : capture_hold_ff[n][15:8];
                    end
                end
            end
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rdata_ff <= RST_BYTE;
        end else begin
            rdata_ff <= i_rd ? rd_mux : RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata = rdata_ff;
    assign o_timer_pin_out = pin_out_ff;
    assign o_timer_pin_oe = pin_oe_ff;
    assign o_capture_event = event_ff;
    assign o_capture_flag_set = flag_set_ff;
    assign o_counter_overflow = overflow_ff;
    assign o_free_running_counter = counter_ff;
    assign o_accum_b_irq = accum_b_overflow_flag_ff & accum_b_control_ff[ACCUM_B_IRQ_ENABLE_BIT];

endmodule // capture_buffer_and_accumulator_b

//--- design/capbuf_pkg.sv
// Register map, field positions and reset values of the capture buffer block
package capbuf_pkg;
    localparam logic [7:0] OFS_TC0 = 8'h90;
    localparam logic [7:0] OFS_ACCUM3_COUNT = 8'ha2;
    localparam logic [7:0] OFS_ACCUM2_COUNT = 8'ha3;
    localparam logic [7:0] OFS_ACCUM1_COUNT = 8'ha4;
    localparam logic [7:0] OFS_ACCUM0_COUNT = 8'ha5;
    localparam logic [7:0] OFS_MODCOUNT_CONTROL = 8'ha6;
    localparam logic [7:0] OFS_ACCUM_ENABLE = 8'ha8;
    localparam logic [7:0] OFS_OVERWRITE_GUARD = 8'haa;
    localparam logic [7:0] OFS_INPUT_CONTROL_SYSTEM = 8'hab;
    localparam logic [7:0] OFS_TIMER_TEST_CONTROL = 8'had;
    localparam logic [7:0] OFS_TIMER_PORT_VALUE = 8'hae;
    localparam logic [7:0] OFS_TIMER_PORT_DIRECTION = 8'haf;
    localparam logic [7:0] OFS_ACCUM_B_CONTROL = 8'hb0;
    localparam logic [7:0] OFS_ACCUM_B_FLAGS = 8'hb1;
    localparam logic [7:0] OFS_ACCUM3_HOLDING = 8'hb2;
    localparam logic [7:0] OFS_ACCUM2_HOLDING = 8'hb3;
    localparam logic [7:0] OFS_ACCUM1_HOLDING = 8'hb4;
    localparam logic [7:0] OFS_ACCUM0_HOLDING = 8'hb5;
    localparam logic [7:0] OFS_TC0_HOLDING = 8'hb8;
    // Input control system fields
    localparam int SHARE_LSB = 4;
    localparam int FLAG_ON_LATCH_BIT = 3;
    localparam int ACCUM_SATURATE_BIT = 2;
    localparam int HOLD_BUFFER_ENABLE_BIT = 1;
    localparam int LATCH_NOT_QUEUE_BIT = 0;
    // Other fields
    localparam int FORCE_LATCH_BIT = 4;
    localparam int DIVIDER_BYPASS_BIT = 1;
    localparam int ACCUM_B_ENABLE_BIT = 6;
    localparam int ACCUM_B_IRQ_ENABLE_BIT = 1;
    localparam int ACCUM_B_OVERFLOW_BIT = 1;
    // Reset values and all-ones constants
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [15:0] WORD_ONES = 16'hffff;
endpackage

//--- tb/capbuf_properties.sv
// Port checker for the capture buffer block
`timescale 1ns/1ps

module capbuf_properties (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_timer_pin,
    input wire logic [7:0] i_compare_active,
    input wire logic [7:0] i_compare_level,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_timer_pin_out,
    input wire logic [7:0] o_timer_pin_oe,
    input wire logic [7:0] o_capture_event,
    input wire logic [3:0] o_capture_flag_set,
    input wire logic o_counter_overflow,
    input wire logic [15:0] o_free_running_counter
);
    logic [7:0] pin_q_ff;
    logic [7:0] rise_q_ff;
    always_ff @(posedge i_core_clk) begin
        pin_q_ff <= i_nrst ? i_timer_pin : 8'h00;
        rise_q_ff <= i_nrst ? (i_timer_pin & ~pin_q_ff) : 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    AST_OE_COMPARE: assert property (i_compare_active != 8'h00 |=>
        ($past(i_compare_active) & ~o_timer_pin_oe) == 8'h00) else $error("compare pin undriven");
    // Write or compare change may move direction
    AST_OE_STABLE: assert property ($past(i_nrst) && !$past(i_wr)
        && $stable(i_compare_active) |=> $stable(o_timer_pin_oe))
        else $error("direction moved without cause");
    AST_LEVEL_COMPARE: assert property (i_compare_active != 8'h00 |=>
        ($past(i_compare_active) & (o_timer_pin_out ^ $past(i_compare_level))) == 8'h00)
        else $error("compare level not on pin");
    AST_FLAG_EVENT: assert property (o_capture_flag_set != 4'h0 |->
        (o_capture_flag_set & ~o_capture_event[3:0]) == 4'h0) else $error("flag without event");
    // Shared channels still need some pin edge
    AST_EVENT_CAUSE: assert property (o_capture_event != 8'h00 |->
        (rise_q_ff | $past(rise_q_ff)) != 8'h00) else $error("event without pin edge");
    AST_OVF_ZERO: assert property (o_counter_overflow |->
        o_free_running_counter[15:8] == 8'h00 || $past(o_free_running_counter[15:8]) == 8'h00)
        else $error("overflow away from rollover");
    AST_OVF_PULSE: assert property (o_counter_overflow |=> !o_counter_overflow)
        else $error("overflow pulse too long");
    cover property (o_counter_overflow);
    cover property (o_capture_flag_set[0]);
    cover property (i_compare_active != 8'h00 ##1 o_timer_pin_oe != 8'h00);
endmodule // capbuf_properties

bind capture_buffer_and_accumulator_b capbuf_properties capbuf_properties_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_wr(i_wr),
    .i_timer_pin(i_timer_pin), .i_compare_active(i_compare_active),
    .i_compare_level(i_compare_level), .o_rdata(o_rdata), .o_timer_pin_out(o_timer_pin_out),
    .o_timer_pin_oe(o_timer_pin_oe), .o_capture_event(o_capture_event),
    .o_capture_flag_set(o_capture_flag_set), .o_counter_overflow(o_counter_overflow),
    .o_free_running_counter(o_free_running_counter));

//--- tb/pin_source.sv
// Pulse source standing in for the signals on the timer pins
`timescale 1ns/1ps

module pin_source (
    input wire logic i_core_clk,
    input wire logic [7:0] i_fire,
    input wire logic [7:0] i_level,
    output logic [7:0] o_pin
);
    logic [7:0] hi1_ff;
    logic [7:0] hi2_ff;
    logic [7:0] hi3_ff;
    // Three cycles high, wider than the input edge detector needs
    always_ff @(posedge i_core_clk) begin
        hi1_ff <= i_fire;
        hi2_ff <= hi1_ff;
        hi3_ff <= hi2_ff;
    end
    assign o_pin = i_level | hi1_ff | hi2_ff | hi3_ff;
endmodule // pin_source

//--- tb/testbench.sv
// Self-checking bench for the capture buffer block
`timescale 1ns/1ps

module testbench
    import capbuf_pkg::*;
;
    logic clk, nrst, wr, rd, spc, ffc, main_timer_enable, tick, mz, ovf, irq;
    logic [7:0] addr, wdata, cact, clev, fire, ext, xpin, pin, rdata, pout, poe, cev;
    logic [3:0] fset;
    logic [3:0] f;
    logic [7:0] g;
    logic [15:0] frc;
    int error_cnt = 0;
    int compares = 0;
    // Wire level from both drivers
    assign pin = (poe & pout) | (~poe & xpin);
    capture_buffer_and_accumulator_b capture_buffer_and_accumulator_b_i (.i_core_clk(clk),
        .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_special_mode(spc), .i_fast_flag_clear(ffc), .i_main_timer_enable(main_timer_enable),
        .i_prescale_tick(tick), .i_accum_a_enable(1'b0), .i_modcount_zero(mz),
        .i_timer_pin(pin), .i_compare_active(cact), .i_compare_level(clev),
        .o_timer_pin_out(pout), .o_timer_pin_oe(poe), .o_capture_event(cev),
        .o_capture_flag_set(fset), .o_counter_overflow(ovf), .o_free_running_counter(frc),
        .o_accum_b_irq(irq));
    pin_source pin_source_i (.i_core_clk(clk), .i_fire(fire), .i_level(ext), .o_pin(xpin));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        rdr(a, v);
        chk(nm, {8'h00, v}, {8'h00, e});
    endtask
    task automatic pulse(input logic [7:0] b);
        f = 4'h0;
        g = 8'h00;
        @(posedge clk);
        fire <= b;
        @(posedge clk);
        fire <= 8'h00;
        repeat (8) begin
            @(posedge clk);
            #1;
            f = f | fset;
            g = g | cev;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rc(8'hc0, 8'h00, "unmapped");
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h02);
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h00);
        rc(OFS_INPUT_CONTROL_SYSTEM, 8'h02, "input_control_system lock");
        wrr(OFS_TIMER_TEST_CONTROL, 8'h02);
        rc(OFS_TIMER_TEST_CONTROL, 8'h00, "test lock");
        spc <= 1'b1;
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h00);
        rc(OFS_INPUT_CONTROL_SYSTEM, 8'h00, "input_control_system special");
    endtask
    task automatic t_port();
        wrr(OFS_TIMER_PORT_DIRECTION, 8'h0f);
        wrr(OFS_TIMER_PORT_VALUE, 8'h87);
        ext <= 8'hf0;
        cact <= 8'h20;
        clev <= 8'h20;
        repeat (2) @(posedge clk);
        #1;
        chk("oe", {8'h00, poe}, 16'h002f);
        chk("drive", {8'h00, pout & 8'h2f}, 16'h0027);
        rc(OFS_TIMER_PORT_VALUE, 8'hd7, "port read");
        cact <= 8'h00;
        ext <= 8'h00;
        repeat (2) @(posedge clk);
        #1;
        chk("oe back", {8'h00, poe}, 16'h000f);
        wrr(OFS_TIMER_PORT_DIRECTION, 8'h00);
    endtask
    task automatic t_flags();
        logic [7:0] md [5] = '{8'h00, 8'h08, 8'h02, 8'h0b, 8'h0a};
        logic [3:0] ex [5] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h0};
        logic [7:0] v;
        logic [15:0] h;
        logic [15:0] c;
        wrr(OFS_OVERWRITE_GUARD, 8'h01);
        foreach (md[k]) begin
            wrr(OFS_INPUT_CONTROL_SYSTEM, md[k]);
            rdr(OFS_TC0, v);
            rdr(OFS_TC0_HOLDING, v);
            pulse(8'h01);
            chk("first flag", {12'h000, f}, {12'h000, ex[k]});
        end
        pulse(8'h01);
        chk("second flag", {12'h000, f}, 16'h0001);
        rdr(OFS_TC0_HOLDING, h[15:8]);
        rdr(OFS_TC0_HOLDING + 8'h01, h[7:0]);
        rdr(OFS_TC0, c[15:8]);
        rdr(OFS_TC0 + 8'h01, c[7:0]);
        chk("queue order", {15'h0000, h < c}, 16'h0001);
    endtask
    task automatic t_accum();
        wrr(OFS_OVERWRITE_GUARD, 8'h00);
        wrr(OFS_ACCUM_ENABLE, 8'h01);
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h03);
        wrr(OFS_ACCUM0_COUNT, 8'hff);
        pulse(8'h01);
        rc(OFS_ACCUM0_COUNT, 8'h00, "wrap");
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h07);
        wrr(OFS_ACCUM0_COUNT, 8'hfe);
        wrr(OFS_ACCUM1_COUNT, 8'h33);
        pulse(8'h01);
        pulse(8'h01);
        rc(OFS_ACCUM0_COUNT, 8'hff, "saturate");
        wrr(OFS_MODCOUNT_CONTROL, 8'h10);
        rc(OFS_ACCUM0_HOLDING, 8'hff, "force latch");
        rc(OFS_ACCUM1_HOLDING, 8'h00, "disabled hold");
        rc(OFS_ACCUM0_COUNT, 8'h00, "latch clear");
        wrr(OFS_ACCUM0_COUNT, 8'h05);
        mz <= 1'b1;
        @(posedge clk);
        mz <= 1'b0;
        rc(OFS_ACCUM0_HOLDING, 8'h05, "zero latch");
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h04);
        wrr(OFS_ACCUM0_COUNT, 8'h09);
        wrr(OFS_MODCOUNT_CONTROL, 8'h10);
        rc(OFS_ACCUM0_HOLDING, 8'h05, "no buffer");
    endtask
    task automatic t_accb();
        main_timer_enable <= 1'b0;
        wrr(OFS_ACCUM_B_CONTROL, 8'h42);
        wrr(OFS_ACCUM1_COUNT, 8'hff);
        wrr(OFS_ACCUM0_COUNT, 8'hff);
        pulse(8'h01);
        rc(OFS_ACCUM1_COUNT, 8'h00, "b high");
        chk("irq", {15'h0000, irq}, 16'h0001);
        wrr(OFS_ACCUM_B_FLAGS, 8'h02);
        chk("irq clear", {15'h0000, irq}, 16'h0000);
        wrr(OFS_ACCUM_B_CONTROL, 8'h00);
        wrr(OFS_ACCUM_ENABLE, 8'h02);
        wrr(OFS_ACCUM1_COUNT, 8'hff);
        // Saturate off so the byte rolls over; pin one also feeds channel five
        wrr(OFS_INPUT_CONTROL_SYSTEM, 8'h20);
        pulse(8'h02);
        chk("share", {8'h00, g}, 16'h0022);
        rc(OFS_ACCUM_B_FLAGS, 8'h02, "one rollover");
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        ffc <= 1'b1;
        rc(OFS_ACCUM0_COUNT, 8'h00, "b low");
        rc(OFS_ACCUM_B_FLAGS, 8'h00, "fast clear");
        ffc <= 1'b0;
    endtask
    task automatic t_bypass();
        bit hit;
        hit = 1'b0;
        main_timer_enable <= 1'b1;
        tick <= 1'b0;
        wrr(OFS_TIMER_TEST_CONTROL, 8'h02);
        rc(OFS_TIMER_TEST_CONTROL, 8'h02, "test write");
        for (int n = 0; n < 600 && !hit; n++) begin
            @(posedge clk);
            #1;
            hit = (ovf === 1'b1);
        end
        chk("bypass overflow", {15'h0000, hit}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        {nrst, wr, rd, spc, ffc, mz, main_timer_enable, tick} = 8'h03;
        {addr, wdata, cact, clev, fire, ext} = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_port();
        t_flags();
        t_accum();
        t_accb();
        t_bypass();
        close_out();
    end
endmodule // testbench
